// ---- pkg/cfg_word_pkg.sv ----
// Constants and carrier types for the configuration word decoder
package cfg_word_pkg;

    // Field layout of the configuration word
    localparam int CFG_WORD_W     = 32;
    localparam int PROT_LSB       = 10;
    localparam int PROT_W         = 9;
    localparam int PROT_SMALL_W   = 7;
    localparam int CHSEL_LSB      = 3;
    localparam int CHSEL_W        = 2;
    localparam int SCAN_BIT       = 2;
    localparam int DBGEN_LSB      = 0;
    localparam int DBGEN_W        = 2;
    localparam int RESV_LSB       = 5;
    localparam int RESV_W         = 5;

    // Protection step of 0x400 bytes
    localparam int PAGE_SHIFT     = 10;

    // Forced debugger field under code protection
    localparam logic [1:0] DBGEN_FORCED = 2'h3;

    // Debug channel codes
    localparam logic [1:0] CHSEL_PAIR1 = 2'h3;
    localparam logic [1:0] CHSEL_PAIR2 = 2'h2;
    localparam logic [1:0] CHSEL_PAIR3 = 2'h1;
    localparam logic [1:0] CHSEL_PAIR4 = 2'h0;

    // Register byte offsets
    localparam int BUS_ADDR_W = 4;
    localparam logic [3:0] OFS_CFG_WORD  = 4'h0;
    localparam logic [3:0] OFS_RT_CTRL   = 4'h4;
    localparam logic [3:0] OFS_STATUS    = 4'h8;
    localparam logic [3:0] OFS_LIMIT     = 4'hc;

    // Register bit positions
    localparam int RT_SCAN_BIT     = 0;
    localparam int ST_LOADED_BIT   = 0;
    localparam int ST_BLOCKED_BIT  = 1;
    localparam int ST_CPROT_BIT    = 2;
    localparam int ST_DISABLED_BIT = 3;
    localparam int ST_ALL_BIT      = 4;

    // Reset values
    localparam logic [31:0] RST_CFG_WORD = 32'hffffffff;
    localparam logic [31:0] RST_RDATA    = 32'h00000000;

    typedef struct packed {
        logic                  read;
        logic                  write;
        logic [BUS_ADDR_W-1:0] address;
        logic [31:0]           writedata;
        logic [3:0]            byteenable;
    } avs_req_type;

    typedef struct packed {
        logic [PROT_W-1:0]  prot;
        logic [CHSEL_W-1:0] chsel;
        logic               scan;
        logic [DBGEN_W-1:0] dbgen;
    } cfg_fields_type;

endpackage

// ---- rtl/protect_limit_calc.sv ----
// Converts the write-protect field into a protected address limit
`timescale 1ns/1ps
`default_nettype none
module protect_limit_calc
#(
    parameter int ADDR_W = 20
)
(
    input  wire logic [cfg_word_pkg::PROT_W-1:0] field_i,
    output logic                                 disabled_o,
    output logic                                 all_o,
    output logic [ADDR_W-1:0]                    limit_o
);
    import cfg_word_pkg::*;

    localparam int LIM_W = PROT_W + PAGE_SHIFT;

    initial
    begin
        if (ADDR_W < LIM_W)
            $error("ADDR_W too small for protect limit");
    end

    logic [LIM_W-1:0] raw_limit;

    always_comb
    begin
        disabled_o = &field_i;
        all_o      = ~|field_i;
        // One page per step below all ones
        raw_limit  = {~field_i, {PAGE_SHIFT{1'b0}}};
        limit_o    = {{(ADDR_W-LIM_W){1'b0}}, raw_limit};
    end
endmodule
`default_nettype wire

// ---- rtl/pin_pair_decode.sv ----
// Decodes the debug channel select code into a one-hot pin pair choice, all zeros for pair 4 when it is not bonded
`timescale 1ns/1ps
`default_nettype none
module pin_pair_decode
(
    input  wire logic [cfg_word_pkg::CHSEL_W-1:0] code_i,
    input  wire logic                             pair4_bonded_i,
    output logic [3:0]                            pair_o
);
    import cfg_word_pkg::*;

    always_comb
    begin
        case (code_i)
            CHSEL_PAIR1: pair_o = 4'h1;
            CHSEL_PAIR2: pair_o = 4'h2;
            CHSEL_PAIR3: pair_o = 4'h4;
            CHSEL_PAIR4: pair_o = pair4_bonded_i ? 4'h8 : 4'h0;
            default:     pair_o = 4'h0;
        endcase
    end
endmodule
`default_nettype wire

// ---- rtl/device_config_word_decoder.sv ----
// Configuration word decoder with flash write guard and register slave
//
// Summary of operation
// - Bits 18..10 hold the flash protect field; all ones means no protection.
// - Each step below all ones protects one more 0x400 byte page upward.
// - Field all zeros protects the whole program flash.
// - Flash writes into the protected region are blocked during execution.
// - Protect bits 8 and 7 exist only on the largest flash variant.
// - Bits 4..3 pick debug pin pair: 11=1, 10=2, 01=3, 00=4.
// - Bit 2 supplies the scan enable bit of the runtime control register.
// - Debugger disabled when bit 1 is one, enabled when zero; bit 0 ignored.
// - Code protection forces the debugger field to 11, disabling it.
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module device_config_word_decoder
    import cfg_word_pkg::*;
#(
    parameter int   ADDR_W       = 20,
    parameter logic LARGE_FLASH  = 1'b1,
    parameter logic PAIR4_BONDED = 1'b1
)
(
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_n_i,
    // Nonvolatile configuration word and code protect state
    input  wire logic [CFG_WORD_W-1:0]       cfg_word_i,
    input  wire logic                        code_protect_i,
    // Flash write check from the flash controller
    input  wire logic                        flash_wr_valid_i,
    input  wire logic [ADDR_W-1:0]           flash_wr_addr_i,
    output logic                             flash_wr_allow_o,
    // Decoded controls
    output logic [3:0]                       debug_pair_sel_o,
    output logic                             scan_port_enable_o,
    output logic                             debug_enable_o,
    output logic                             cfg_loaded_o,
    // Avalon-MM slave
    input  wire cfg_word_pkg::avs_req_type   avs_req_i,
    output logic [31:0]                      avs_readdata_o,
    output logic                             avs_waitrequest_o
);

    initial
    begin
        if (ADDR_W < PROT_W + PAGE_SHIFT || ADDR_W > 32)
            $error("ADDR_W out of range");
    end

    typedef struct packed {
        logic           loaded;
        cfg_fields_type cfg;
        logic           cprot;
        logic           scan_en;
        logic           blocked;
        logic           ack;
        logic [31:0]    rdata;
    } state_type;

    state_type state_q;
    state_type state_d;

    logic [PROT_W-1:0] prot_eff;
    logic              prot_disabled;
    logic              prot_all;
    logic [ADDR_W-1:0] prot_limit;
    logic [3:0]        pair_sel;
    logic              in_region;
    logic              wr_block;
    logic              bus_req;
    logic              bus_fire;
    logic [31:0]       cfg_view;
    logic [31:0]       rt_view;
    logic [31:0]       st_view;
    logic [31:0]       lim_view;
    logic [31:0]       rd_mux;
    logic [31:0]       wmask;
    logic [31:0]       rt_new;

    // Small variants have no upper protect bits; they act as ones
    generate
        if (LARGE_FLASH)
        begin : g_large
            assign prot_eff = state_q.cfg.prot;
        end
        else
        begin : g_small
            assign prot_eff = {{(PROT_W-PROT_SMALL_W){1'b1}},
                               state_q.cfg.prot[PROT_SMALL_W-1:0]};
        end
    endgenerate

    protect_limit_calc
    #(
        .ADDR_W     (ADDR_W)
    )
    u_limit
    (
        .field_i    (prot_eff),
        .disabled_o (prot_disabled),
        .all_o      (prot_all),
        .limit_o    (prot_limit)
    );

    pin_pair_decode u_pairs
    (
        .code_i         (state_q.cfg.chsel),
        .pair4_bonded_i (PAIR4_BONDED),
        .pair_o         (pair_sel)
    );

    // Until the word is loaded the flash is treated as fully protected
    always_comb
    begin
        in_region = prot_all
                  | (!prot_disabled && (flash_wr_addr_i < prot_limit));
        wr_block  = flash_wr_valid_i
                  & (~state_q.loaded | in_region);
    end

    assign flash_wr_allow_o = flash_wr_valid_i & ~wr_block;

    // Bus: one wait cycle, answer on the second cycle of each request
    always_comb
    begin
        bus_req  = avs_req_i.read | avs_req_i.write;
        bus_fire = bus_req & state_q.ack;
    end

    assign avs_waitrequest_o = bus_req & ~state_q.ack;

    always_comb
    begin
        cfg_view = RST_RDATA;
        cfg_view[PROT_LSB +: PROT_W]   = prot_eff;
        cfg_view[RESV_LSB +: RESV_W]   = {RESV_W{1'b1}};
        cfg_view[CHSEL_LSB +: CHSEL_W] = state_q.cfg.chsel;
        cfg_view[SCAN_BIT]             = state_q.cfg.scan;
        cfg_view[DBGEN_LSB +: DBGEN_W] = state_q.cfg.dbgen;

        rt_view = RST_RDATA;
        rt_view[RT_SCAN_BIT] = state_q.scan_en;

        st_view = RST_RDATA;
        st_view[ST_LOADED_BIT]   = state_q.loaded;
        st_view[ST_BLOCKED_BIT]  = state_q.blocked;
        st_view[ST_CPROT_BIT]    = state_q.cprot;
        st_view[ST_DISABLED_BIT] = prot_disabled;
        st_view[ST_ALL_BIT]      = prot_all;

        lim_view = RST_RDATA;
        lim_view[ADDR_W-1:0] = prot_limit;

        case (avs_req_i.address)
            OFS_CFG_WORD: rd_mux = cfg_view;
            OFS_RT_CTRL:  rd_mux = rt_view;
            OFS_STATUS:   rd_mux = st_view;
            OFS_LIMIT:    rd_mux = lim_view;
            default:      rd_mux = RST_RDATA;
        endcase

        for (int i = 0; i < 4; i++)
        begin
            wmask[i*8 +: 8] = {8{avs_req_i.byteenable[i]}};
        end
        rt_new = (rt_view & ~wmask) | (avs_req_i.writedata & wmask);
    end

    always_comb
    begin
        state_d = state_q;

        // Capture once, on the first edge after reset release
        if (!state_q.loaded)
        begin
            state_d.loaded    = 1'b1;
            state_d.cfg.prot  = cfg_word_i[PROT_LSB +: PROT_W];
            state_d.cfg.chsel = cfg_word_i[CHSEL_LSB +: CHSEL_W];
            state_d.cfg.scan  = cfg_word_i[SCAN_BIT];
            state_d.scan_en   = cfg_word_i[SCAN_BIT];
            state_d.cprot     = code_protect_i;
            if (code_protect_i)
            begin
                state_d.cfg.dbgen = DBGEN_FORCED;
            end
            else
            begin
                state_d.cfg.dbgen = cfg_word_i[DBGEN_LSB +: DBGEN_W];
            end
        end

        // Bus answer and register writes
        state_d.ack = bus_req & ~state_q.ack;
        if (bus_req && !state_q.ack && avs_req_i.read)
        begin
            state_d.rdata = rd_mux;
        end

        if (bus_fire && avs_req_i.write)
        begin
            case (avs_req_i.address)
                OFS_RT_CTRL:
                begin
                    state_d.scan_en = rt_new[RT_SCAN_BIT];
                end
                OFS_STATUS:
                begin
                    if (avs_req_i.byteenable[0]
                        && avs_req_i.writedata[ST_BLOCKED_BIT])
                    begin
                        state_d.blocked = 1'b0;
                    end
                end
                default:
                begin
                    state_d.blocked = state_q.blocked;
                end
            endcase
        end

        // A new block wins over a clear in the same cycle
        if (wr_block)
        begin
            state_d.blocked = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_q.loaded    <= 1'b0;
            state_q.cfg       <= RST_CFG_WORD[$bits(cfg_fields_type)-1:0];
            state_q.cprot     <= 1'b0;
            state_q.scan_en   <= 1'b0;
            state_q.blocked   <= 1'b0;
            state_q.ack       <= 1'b0;
            state_q.rdata     <= RST_RDATA;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Controls stay off until the word has been captured
    assign debug_pair_sel_o   = state_q.loaded ? pair_sel : 4'h0;
    assign scan_port_enable_o = state_q.loaded & state_q.scan_en;
    assign debug_enable_o     = state_q.loaded
                              & ~state_q.cfg.dbgen[1];
    assign cfg_loaded_o       = state_q.loaded;
    assign avs_readdata_o     = state_q.rdata;

endmodule
`default_nettype wire

// ---- verification/cfg_decoder_monitor.sv ----
// Port assertions for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module cfg_decoder_monitor
    import cfg_word_pkg::*;
#(
    parameter int ADDR_W = 20
)
(
    input wire logic                      core_clk_i,
    input wire logic                      rst_n_i,
    input wire logic [31:0]               cfg_word_i,
    input wire logic                      code_protect_i,
    input wire logic                      flash_wr_valid_i,
    input wire logic [ADDR_W-1:0]         flash_wr_addr_i,
    input wire logic                      flash_wr_allow_o,
    input wire logic [3:0]                debug_pair_sel_o,
    input wire logic                      scan_port_enable_o,
    input wire logic                      debug_enable_o,
    input wire logic                      cfg_loaded_o,
    input wire cfg_word_pkg::avs_req_type avs_req_i,
    input wire logic [31:0]               avs_readdata_o,
    input wire logic                      avs_waitrequest_o
);
    // Own copy of the captured word, so checks do not trust the design
    logic              seen_q;
    logic [31:0]       cw_q;
    logic              cp_q;
    logic [8:0]        f_w;
    logic [ADDR_W:0]   lim_w;
    assign f_w = cw_q[18:10];
    assign lim_w = (ADDR_W+1)'({~f_w, 10'h0});
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            seen_q <= 1'b0;
        else if (!seen_q)
        begin
            seen_q <= 1'b1;
            cw_q   <= cfg_word_i;
            cp_q   <= code_protect_i;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_LOADED: assert property (seen_q |-> cfg_loaded_o)
        else $error("loaded flag low after capture");
    AST_PAIR: assert property (seen_q |->
        debug_pair_sel_o == 4'h1 << (2'h3 - cw_q[4:3]))
        else $error("wrong debug pin pair");
    AST_DEBUG: assert property (seen_q |->
        debug_enable_o == !(cp_q | cw_q[1]))
        else $error("wrong debugger enable");
    AST_HELD: assert property (cfg_loaded_o && $past(cfg_loaded_o) |->
        $stable(debug_enable_o) && $stable(debug_pair_sel_o))
        else $error("decoded control changed after capture");
    AST_SCAN: assert property ($rose(cfg_loaded_o) |->
        scan_port_enable_o == cw_q[2])
        else $error("scan enable default wrong");
    AST_OFF: assert property (seen_q && f_w == 9'h1ff && flash_wr_valid_i
        |-> flash_wr_allow_o)
        else $error("write blocked with protection off");
    AST_ALL: assert property (seen_q && f_w == 9'h0 |-> !flash_wr_allow_o)
        else $error("write allowed with whole flash protected");
    AST_LIMIT: assert property (seen_q && flash_wr_valid_i && f_w != 9'h0
        |-> flash_wr_allow_o == ({1'b0, flash_wr_addr_i} >= lim_w))
        else $error("protect limit wrong");
    AST_VALID: assert property (!flash_wr_valid_i || !cfg_loaded_o
        |-> !flash_wr_allow_o)
        else $error("allow without a valid write");
    AST_WAIT: assert property ($rose(avs_req_i.read) |->
        avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("read wait not one cycle");
    C_LOAD: cover property ($rose(cfg_loaded_o));
    C_BLOCK: cover property (flash_wr_valid_i && !flash_wr_allow_o);
    C_WRITE: cover property (avs_req_i.write && !avs_waitrequest_o);
endmodule
bind device_config_word_decoder cfg_decoder_monitor #(.ADDR_W(ADDR_W)) mon_u
(
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cfg_word_i(cfg_word_i),
    .code_protect_i(code_protect_i), .flash_wr_valid_i(flash_wr_valid_i),
    .flash_wr_addr_i(flash_wr_addr_i), .flash_wr_allow_o(flash_wr_allow_o),
    .debug_pair_sel_o(debug_pair_sel_o), .debug_enable_o(debug_enable_o),
    .scan_port_enable_o(scan_port_enable_o), .cfg_loaded_o(cfg_loaded_o),
    .avs_req_i(avs_req_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o)
);
`default_nettype wire

// ---- verification/device_config_word_decoder_bench.sv ----
// Self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module device_config_word_decoder_bench;
    import cfg_word_pkg::*;
    localparam int AW = 20;
    logic        clk, rst_n, cp, fv, allow, scan, dbg, loaded, wt, sc, cpv, v;
    logic [31:0] cw, rd, q, w, e;
    logic [AW-1:0] fa;
    logic [3:0]  pair;
    logic [8:0]  fld;
    logic [1:0]  code;
    avs_req_type req;
    int          err_count, total_checks, seed, lim, a, blk;

    device_config_word_decoder #(.ADDR_W(AW)) dut_u
    (
        .core_clk_i(clk), .rst_n_i(rst_n), .cfg_word_i(cw),
        .code_protect_i(cp), .flash_wr_valid_i(fv), .flash_wr_addr_i(fa),
        .flash_wr_allow_o(allow), .debug_pair_sel_o(pair),
        .scan_port_enable_o(scan), .debug_enable_o(dbg),
        .cfg_loaded_o(loaded), .avs_req_i(req), .avs_readdata_o(rd),
        .avs_waitrequest_o(wt)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Entered just after an edge; holds the request until waitrequest low
    task automatic bus(input logic wr, input logic [3:0] ad,
                       input logic [31:0] d, output logic [31:0] r);
        req.read <= !wr;
        req.write <= wr;
        req.address <= ad;
        req.writedata <= d;
        @(posedge clk);
        while (wt)
            @(posedge clk);
        r = rd;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic summarize();
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        summarize();
    end

    initial
    begin
        seed = 32'h49a5d1c8;
        {rst_n, cp, fv, fa, cw} = '0;
        req = '{1'b0, 1'b0, 4'h0, 32'h0, 4'hf};
        for (int i = 0; i < 8; i++)
        begin
            fld = (i == 0) ? 9'h1ff : (i == 1) ? 9'h0 : (i == 2) ? 9'h1fe
                : 9'($random(seed));
            code = i[1:0];
            sc = i[1];
            cpv = (i > 5);
            w = $random(seed);
            w[18:10] = fld;
            w[4:3] = code;
            w[2] = sc;
            rst_n <= 1'b0;
            cw <= w;
            cp <= cpv;
            repeat (16) @(posedge clk);
            chk("loaded_rst", loaded, 0);
            rst_n <= 1'b1;
            repeat (2) @(posedge clk);
            cw <= ~w; // Later changes must not reach the controls
            repeat (2) @(posedge clk);
            chk("loaded", loaded, 1);
            chk("pair", pair, 4'h1 << (3 - code));
            chk("debug", dbg, !(cpv | w[1]));
            chk("scan", scan, sc);
            bus(1'b0, 4'h4, 32'h0, q);
            chk("rt_scan", q[0], sc);
            bus(1'b1, 4'h4, {31'h0, !sc}, q);
            chk("scan_wr", scan, !sc);
            bus(1'b0, 4'h2, 32'h0, q);
            chk("unmapped", q, 0);
            bus(1'b0, 4'h8, 32'h0, q);
            chk("status", q & 32'h1d,
                {fld == 9'h0, fld == 9'h1ff, cpv, 2'h1});
            lim = (511 - fld) * 1024;
            blk = 0;
            bus(1'b0, 4'hc, 32'h0, q);
            chk("limit", q, lim);
            // Config word is read only: a write must leave the view intact
            bus(1'b1, 4'h0, 32'h0, q);
            bus(1'b0, 4'h0, 32'h0, q);
            e = {13'h0, fld, 5'h1f, code, sc, cpv ? 2'h3 : w[1:0]};
            chk("cfg_view", q, e);
            for (int j = 0; j < 6; j++)
            begin
                a = (j == 0) ? lim - 1 : (j == 1) ? lim : (j == 2) ? 0
                    : (j == 3) ? 'hfffff : $random(seed);
                a = a & 'hfffff;
                v = (j != 5);
                fv <= v;
                fa <= AW'(a);
                @(posedge clk);
                chk("allow", allow, v && fld != 0 && a >= lim);
                if (v && !(fld != 0 && a >= lim))
                    blk = 1;
            end
            fv <= 1'b0;
            bus(1'b0, 4'h8, 32'h0, q);
            chk("blocked", q[1], blk);
            bus(1'b1, 4'h8, 32'h2, q);
            bus(1'b0, 4'h8, 32'h0, q);
            chk("blk_clr", q[1], 0);
        end
        summarize();
    end
endmodule
`default_nettype wire
